// ### src/sfc_pkg.sv
// package: register map, field layout, frame constants and shared helpers
package sfc_pkg;
  // ----------------------------------------------------------------
  // register offsets (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_CTL1  = 3'h0;  // serial_frame_control
  localparam logic [2:0] OFS_STAT  = 3'h1;
  localparam logic [2:0] OFS_DATA  = 3'h2;
  localparam logic [2:0] OFS_BAUD  = 3'h3;
  localparam logic [2:0] OFS_CTL2  = 3'h4;
  localparam logic [2:0] OFS_IST   = 3'h5;
  localparam logic [2:0] OFS_IMSK  = 3'h6;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CF_RX9  = 7;  // receive_ninth_bit
  localparam int unsigned CF_TX9  = 6;  // transmit_ninth_bit
  localparam int unsigned CF_STOP = 5;  // serial_low_power_stop
  localparam int unsigned CF_W9   = 4;  // nine-bit word length
  localparam int unsigned CF_WAKE = 3;  // mute exit: 0 idle, 1 address mark
  localparam int unsigned CF_PCE  = 2;  // parity_control_enable
  localparam int unsigned CF_PODD = 1;  // parity_odd_select
  localparam int unsigned CF_PIE  = 0;  // parity_error_irq_enable
  localparam int unsigned ST_TDRE = 7;
  localparam int unsigned ST_TC   = 6;
  localparam int unsigned ST_RDRF = 5;
  localparam int unsigned ST_IDLE = 4;
  localparam int unsigned ST_FE   = 1;
  localparam int unsigned ST_PE   = 0;  // parity_error_flag
  localparam int unsigned C2_TXEN = 0;
  localparam int unsigned C2_RXEN = 1;
  localparam int unsigned C2_MUTE = 2;
  localparam int unsigned IR_PE   = 0;
  localparam int unsigned IR_RX   = 1;
  localparam int unsigned IR_TX   = 2;
  localparam int unsigned IR_IDLE = 3;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h0f;  // bit time = divisor + 1 clocks
  localparam logic [3:0] IMSK_RST = 4'h0;
  localparam logic [3:0] DBITS8   = 4'h8;
  localparam logic [3:0] DBITS9   = 4'h9;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} sfc_tx_e;
  typedef enum logic [3:0] {RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4,
                            RX_STOP = 4'h8} sfc_rx_e;
  // parity bit over the data bits: even makes the total of ones even
  function automatic logic sfc_parity(input logic [8:0] b, input logic odd);
    return (^b) ^ odd;
  endfunction : sfc_parity
  // bit times per frame: start, data, stop
  function automatic logic [3:0] sfc_frame_len(input logic w9);
    return (w9 ? DBITS9 : DBITS8) + 4'h2;
  endfunction : sfc_frame_len
endpackage : sfc_pkg

// ### src/sfc_fmt_if.sv
// interface: frame format and prescaler settings shared by tx and rx
`timescale 1ns/1ps
`default_nettype none
interface sfc_fmt_if;
  logic       word9;
  logic       par_en;
  logic       par_odd;
  logic       halt;
  logic [7:0] div;
  modport src  (output word9, par_en, par_odd, halt, div);
  modport sink (input  word9, par_en, par_odd, halt, div);
endinterface : sfc_fmt_if
`default_nettype wire

// ### src/sfc_tx.sv
// transmit framer: start, 8 or 9 data bits, stop, lsb first
`timescale 1ns/1ps
`default_nettype none
module sfc_tx (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  sfc_fmt_if.sink         fmt,
  input  wire logic       i_start,
  input  wire logic [7:0] i_data,
  input  wire logic       i_bit8,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_txd
);
  import sfc_pkg::*;
  sfc_tx_e     state_r;
  logic [10:0] shf_r;
  logic [7:0]  cnt_r;
  logic [3:0]  nbit_r;
  logic [8:0]  word;
  // top data slot carries parity or plain data; 8-bit frames put stop in bit 8
  always_comb begin
    word = {i_bit8, i_data};
    if (fmt.word9 && fmt.par_en) word[8] = sfc_parity({1'b0, i_data}, fmt.par_odd);
    if (!fmt.word9) word[8] = 1'b1;
    if (!fmt.word9 && fmt.par_en) word[7] = sfc_parity({2'b00, i_data[6:0]}, fmt.par_odd);
  end
  // format is sampled only at frame start, so changes wait for the next byte
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= TX_IDLE;
      shf_r   <= 11'h7ff;
      cnt_r   <= 8'h00;
      nbit_r  <= 4'h0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_r)
        TX_IDLE: begin
          if (i_start && !fmt.halt) begin
            state_r <= TX_SEND;
            shf_r   <= {1'b1, word, 1'b0};
            cnt_r   <= fmt.div;
            nbit_r  <= sfc_frame_len(fmt.word9);
          end
        end
        TX_SEND: begin
          if (cnt_r == 8'h00) begin
            cnt_r  <= fmt.div;
            shf_r  <= {1'b1, shf_r[10:1]};
            nbit_r <= nbit_r - 4'h1;
            if (nbit_r == 4'h1) begin
              state_r <= TX_IDLE;
              o_done  <= 1'b1;
            end
          end else cnt_r <= cnt_r - 8'h01;
        end
        default: state_r <= TX_IDLE;
      endcase
    end
  end
  assign o_busy = (state_r == TX_SEND);
  assign o_txd  = shf_r[0];
endmodule : sfc_tx
`default_nettype wire

// ### src/sfc_rx.sv
// receive deframer with parity check and idle-line detection
`timescale 1ns/1ps
`default_nettype none
module sfc_rx (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  sfc_fmt_if.sink         fmt,
  input  wire logic       i_rxd,
  output logic            o_done,
  output logic [7:0]      o_data,
  output logic            o_bit8,
  output logic            o_nine,
  output logic            o_perr,
  output logic            o_ferr,
  output logic            o_idle
);
  import sfc_pkg::*;
  sfc_rx_e    state_r;
  logic [7:0] cnt_r;
  logic [3:0] nbit_r;
  logic [3:0] idle_r;
  logic       idle_arm_r;
  logic       w9_r;
  logic       pen_r;
  logic       podd_r;
  logic [8:0] sh_r;
  logic [8:0] word;
  logic       bad;
  // 8-bit frames land in sh_r[8:1]; parity sits in the top data slot
  assign word = w9_r ? sh_r : {1'b0, sh_r[8:1]};
  assign bad  = w9_r ? (sfc_parity({1'b0, word[7:0]}, podd_r) != word[8])
                     : (sfc_parity({2'b00, word[6:0]}, podd_r) != word[7]);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r    <= RX_IDLE;
      cnt_r      <= 8'h00;
      nbit_r     <= 4'h0;
      idle_r     <= 4'h0;
      idle_arm_r <= 1'b0;
      w9_r       <= 1'b0;
      pen_r      <= 1'b0;
      podd_r     <= 1'b0;
      sh_r       <= 9'h000;
      o_done     <= 1'b0;
      o_data     <= 8'h00;
      o_bit8     <= 1'b0;
      o_nine     <= 1'b0;
      o_perr     <= 1'b0;
      o_ferr     <= 1'b0;
      o_idle     <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_idle <= 1'b0;
      case (state_r)
        RX_IDLE: begin
          if (!i_rxd && !fmt.halt) begin
            state_r <= RX_START;
            cnt_r   <= {1'b0, fmt.div[7:1]};  // aim at mid start bit
            idle_r  <= 4'h0;
            w9_r    <= fmt.word9;
            pen_r   <= fmt.par_en;
            podd_r  <= fmt.par_odd;
          end else if (fmt.halt) cnt_r <= fmt.div;  // prescaler stopped
          else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
          else begin
            cnt_r <= fmt.div;
            if (idle_r != sfc_frame_len(fmt.word9)) idle_r <= idle_r + 4'h1;
            else if (idle_arm_r) begin
              o_idle     <= 1'b1;
              idle_arm_r <= 1'b0;
            end
          end
        end
        RX_START: begin
          if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
          else begin
            state_r <= i_rxd ? RX_IDLE : RX_DATA;  // glitch rejected
            cnt_r   <= fmt.div;
            nbit_r  <= w9_r ? DBITS9 : DBITS8;
          end
        end
        RX_DATA: begin
          if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
          else begin
            sh_r   <= {i_rxd, sh_r[8:1]};
            cnt_r  <= fmt.div;
            nbit_r <= nbit_r - 4'h1;
            if (nbit_r == 4'h1) state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
          else begin
            state_r    <= RX_IDLE;
            cnt_r      <= fmt.div;
            idle_arm_r <= 1'b1;
            o_done     <= 1'b1;
            o_data     <= word[7:0];
            o_bit8     <= word[8];
            o_nine     <= w9_r;
            o_perr     <= pen_r && bad;
            o_ferr     <= !i_rxd;
          end
        end
        default: state_r <= RX_IDLE;
      endcase
    end
  end
endmodule : sfc_rx
`default_nettype wire

// ### src/sfc_serial_frame_control.sv
// serial interface top: frame control register, status, data and link logic
//
// Contract
// - in nine-bit mode the received ninth bit is stored in control bit 7.
// - in nine-bit mode control bit 6 is sent as ninth data bit.
// - low-power stop halts prescalers and outputs after the current byte.
// - bit 4 picks 8 or 9 data bits, always one start and stop.
// - bit 3 picks mute exit by idle line or by address mark.
// - parity occupies the top data slot when enabled; every received word checked.
// - parity enable change applies only after the byte in progress.
// - bit 1 picks even or odd parity, applied from the next byte.
// - parity interrupt enable raises interrupt while the parity error flag is set.
// - reset clears control bits 6 to 0; bit 7 has no defined value.
// - parity error flag set on failure, cleared by status read then data access.
`timescale 1ns/1ps
`default_nettype none
module sfc_serial_frame_control (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  input  wire logic       i_rxd,
  output logic            o_txd,
  output logic            o_txd_oe,
  output logic            o_irq
);
  import sfc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // software-visible state
  logic [7:0] ctl1_r;
  logic [7:0] ctl2_r;
  logic [7:0] baud_r;
  logic       mute_r;
  logic [7:0] tdr_r;
  logic       tdr_bit8_r;
  logic       tdre_r;
  logic       tc_r;
  logic [7:0] rdr_r;
  logic       rdrf_r;
  logic       idle_r;
  logic       fe_r;
  logic       pe_r;
  logic       seq_r;
  logic [3:0] ist_r;
  logic [3:0] imsk_r;
  logic [7:0] rdata_r;

  // synchroniser stages
  logic       rxd_meta_r;
  logic       rxd_sync_r;

  // port strobes
  logic       wr_ctl1;
  logic       wr_ctl2;
  logic       wr_baud;
  logic       wr_data;
  logic       wr_imsk;
  logic       rd_stat;
  logic       rd_data;
  logic       rd_ist;
  logic       data_acc;

  // framer handshakes
  logic       tx_go;
  logic       tx_busy;
  logic       tx_done;
  logic       tx_line;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_bit8;
  logic       rx_nine;
  logic       rx_perr;
  logic       rx_ferr;
  logic       rx_idle;

  // wake and flag qualifiers
  logic       rx_msb;
  logic       wake_addr;
  logic       wake_idle;
  logic       rx_take;
  logic       idle_take;
  logic [3:0] ev;

  sfc_fmt_if fmt ();

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic stb, input logic [2:0] a,
                               input logic [2:0] ofs);
    return stb && (a == ofs);
  endfunction : hit

  // one strobe per cycle, so at most one of these is high
  assign wr_ctl1  = hit(i_wr, i_addr, OFS_CTL1);
  assign wr_ctl2  = hit(i_wr, i_addr, OFS_CTL2);
  assign wr_baud  = hit(i_wr, i_addr, OFS_BAUD);
  assign wr_data  = hit(i_wr, i_addr, OFS_DATA);
  assign wr_imsk  = hit(i_wr, i_addr, OFS_IMSK);
  assign rd_stat  = hit(i_rd, i_addr, OFS_STAT);
  assign rd_data  = hit(i_rd, i_addr, OFS_DATA);
  assign rd_ist   = hit(i_rd, i_addr, OFS_IST);
  assign data_acc = wr_data || rd_data;

  // ----------------------------------------------------------------
  // receive pin synchroniser
  // ----------------------------------------------------------------
  // second stage is the only reader of the first
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rxd_meta_r <= 1'b1;
      rxd_sync_r <= 1'b1;
    end else begin
      rxd_meta_r <= i_rxd;
      rxd_sync_r <= rxd_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // frame control register
  // ----------------------------------------------------------------
  // bit 7 is hardware-written only; a software write leaves it alone
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl1_r <= CTL1_RST;  // bit 7 given zero as its don't-care value
    end else begin
      if (wr_ctl1) ctl1_r[CF_TX9:0] <= i_wdata[CF_TX9:0];
      if (rx_take && rx_nine) ctl1_r[CF_RX9] <= rx_bit8;
    end
  end

  // ----------------------------------------------------------------
  // link settings handed to the framers
  // ----------------------------------------------------------------
  // framers latch format and parity at frame start, so those land on the next byte; the divisor is reloaded every bit
  assign fmt.word9   = ctl1_r[CF_W9];
  assign fmt.par_en  = ctl1_r[CF_PCE];
  assign fmt.par_odd = ctl1_r[CF_PODD];
  assign fmt.halt    = ctl1_r[CF_STOP];
  assign fmt.div     = baud_r;

  // ----------------------------------------------------------------
  // enables, divisor, mute
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl2_r <= CTL2_RST;
      baud_r <= BAUD_RST;
    end else begin
      if (wr_ctl2) ctl2_r <= {5'h00, 1'b0, i_wdata[C2_RXEN], i_wdata[C2_TXEN]};
      if (wr_baud) baud_r <= i_wdata;
    end
  end

  // top data slot of the word: address mark candidate
  assign rx_msb    = rx_nine ? rx_bit8 : rx_data[7];
  assign wake_addr = rx_done && ctl1_r[CF_WAKE] && rx_msb;
  assign wake_idle = rx_idle && !ctl1_r[CF_WAKE];

  // software enters mute; hardware leaves it on the chosen wake event
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mute_r <= 1'b0;
    end else if (wr_ctl2) begin
      mute_r <= i_wdata[C2_MUTE];
    end else if (mute_r && (wake_addr || wake_idle)) begin
      mute_r <= 1'b0;
    end
  end

  // the waking address word itself is delivered
  assign rx_take   = rx_done && ctl2_r[C2_RXEN] && (!mute_r || wake_addr);
  assign idle_take = rx_idle && ctl2_r[C2_RXEN] && !mute_r;

  // ----------------------------------------------------------------
  // transmit holding register
  // ----------------------------------------------------------------
  // handover only while the framer is idle
  assign tx_go = !tdre_r && ctl2_r[C2_TXEN] && !fmt.halt && !tx_busy;

  // ninth bit frozen with the data byte
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tdr_r      <= 8'h00;
      tdr_bit8_r <= 1'b0;
    end else if (wr_data) begin
      tdr_r      <= i_wdata;
      tdr_bit8_r <= ctl1_r[CF_TX9];
    end
  end

  // write empties nothing: it fills; handover to the framer empties
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tdre_r <= 1'b1;
      tc_r   <= 1'b0;
    end else begin
      if (wr_data) tdre_r <= 1'b0;
      else if (tx_go) tdre_r <= 1'b1;
      if (wr_data) tc_r <= 1'b0;
      if (tx_done) tc_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer and flags
  // ----------------------------------------------------------------
  // clear sequence: status read arms, next data access consumes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      seq_r <= 1'b0;
    end else if (rd_stat) begin
      seq_r <= 1'b1;
    end else if (data_acc) begin
      seq_r <= 1'b0;
    end
  end

  // no overrun tracking: a new word overwrites
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdr_r <= 8'h00;
    end else if (rx_take) begin
      rdr_r <= rx_data;
    end
  end

  // set after clear in each flag, so an event in the clear cycle survives
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdrf_r <= 1'b0;
      idle_r <= 1'b0;
      fe_r   <= 1'b0;
      pe_r   <= 1'b0;
    end else begin
      if (seq_r && rd_data) begin
        rdrf_r <= 1'b0;
        idle_r <= 1'b0;
        fe_r   <= 1'b0;
      end
      if (seq_r && data_acc) pe_r <= 1'b0;
      if (rx_take) rdrf_r <= 1'b1;
      if (idle_take) idle_r <= 1'b1;
      if (rx_take && rx_ferr) fe_r <= 1'b1;
      if (rx_take && rx_perr) pe_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // one-cycle event pulses
  assign ev[IR_PE]   = rx_take && rx_perr;
  assign ev[IR_RX]   = rx_take;
  assign ev[IR_TX]   = tx_done;
  assign ev[IR_IDLE] = idle_take;

  // read clears, but a same-cycle event is kept
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ist_r <= 4'h0;
    end else begin
      ist_r <= (rd_ist ? 4'h0 : ist_r) | ev;
    end
  end

  // mask gates only the output
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      imsk_r <= IMSK_RST;
    end else if (wr_imsk) begin
      imsk_r <= i_wdata[3:0];
    end
  end

  // parity interrupt enable acts on the live flag, independent of the mask
  assign o_irq = (|(ist_r & imsk_r)) || (ctl1_r[CF_PIE] && pe_r);

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  // idle cycles return zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else if (!i_rd) begin
      rdata_r <= 8'h00;
    end else begin
      case (i_addr)
        OFS_CTL1: rdata_r <= ctl1_r;
        OFS_STAT: rdata_r <= {tdre_r, tc_r, rdrf_r, idle_r, 2'b00, fe_r, pe_r};
        OFS_DATA: rdata_r <= rdr_r;
        OFS_BAUD: rdata_r <= baud_r;
        OFS_CTL2: rdata_r <= {5'h00, mute_r, ctl2_r[C2_RXEN], ctl2_r[C2_TXEN]};
        OFS_IST:  rdata_r <= {4'h0, ist_r};
        OFS_IMSK: rdata_r <= {4'h0, imsk_r};
        default:  rdata_r <= 8'h00;
      endcase
    end
  end
  assign o_rdata = rdata_r;

  // ----------------------------------------------------------------
  // framers and pin drive
  // ----------------------------------------------------------------
  sfc_tx u_tx (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .fmt     (fmt.sink),
    .i_start (tx_go),
    .i_data  (tdr_r),
    .i_bit8  (tdr_bit8_r),
    .o_busy  (tx_busy),
    .o_done  (tx_done),
    .o_txd   (tx_line)
  );

  // disabled receiver sees an idle line
  sfc_rx u_rx (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .fmt    (fmt.sink),
    .i_rxd  (rxd_sync_r || !ctl2_r[C2_RXEN]),
    .o_done (rx_done),
    .o_data (rx_data),
    .o_bit8 (rx_bit8),
    .o_nine (rx_nine),
    .o_perr (rx_perr),
    .o_ferr (rx_ferr),
    .o_idle (rx_idle)
  );

  // output released once the stop is set and the frame has drained
  assign o_txd    = tx_line;
  assign o_txd_oe = ctl2_r[C2_TXEN] && !(fmt.halt && !tx_busy);

endmodule : sfc_serial_frame_control
`default_nettype wire

// ### sim/sfc_serial_frame_control_chk.sv
// checker: port-level assertions for the serial frame control block
`timescale 1ns/1ps
`default_nettype none
module sfc_chk (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_rxd,
  input wire logic       o_txd,
  input wire logic       o_txd_oe,
  input wire logic       o_irq
);
  logic [6:0] ctl_r;
  logic       txen_r;
  logic [3:0] msk_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // shadow of software writes
  // ----------------------------------------------------------------
  // tracks settings so outputs can be tied to what software asked for
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl_r  <= 7'h00;
      txen_r <= 1'b0;
      msk_r  <= 4'h0;
    end else if (i_wr && i_addr == 3'h0) begin
      ctl_r <= i_wdata[6:0];
    end else if (i_wr && i_addr == 3'h4) begin
      txen_r <= i_wdata[0];
    end else if (i_wr && i_addr == 3'h6) begin
      msk_r <= i_wdata[3:0];
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  rst_clear_a: assert property ($past(i_rst) && i_rd && i_addr == 3'h0 |=>
    o_rdata[6:0] == 7'h00) else $error("control bits not clear after reset");
  ctl_readback_a: assert property (i_rd && i_addr == 3'h0 |=>
    o_rdata[6:0] == ctl_r) else $error("control readback differs");
  read_unmap_a: assert property (i_rd && i_addr == 3'h7 ##1 1'b1 |->
    o_rdata == 8'h00) else $error("unmapped read not zero");
  pie_off_a: assert property (!ctl_r[0] && msk_r == 4'h0 |-> !o_irq)
    else $error("interrupt while all enables off");
  pie_on_a: assert property ($past(i_rd) && $past(i_addr) == 3'h1 && o_rdata[0]
    && ctl_r[0] |-> o_irq) else $error("parity error without interrupt");
  oe_on_a: assert property (txen_r && !ctl_r[5] |-> o_txd_oe)
    else $error("tx pin not driven while enabled");
  oe_off_a: assert property (!txen_r |-> !o_txd_oe)
    else $error("tx pin driven while disabled");
  txd_idle_a: assert property (!txen_r |-> o_txd)
    else $error("tx line not idle high");
  cover property (i_rd && i_addr == 3'h1 ##1 o_rdata[0]);
  cover property (o_irq);
  cover property ($fell(o_txd_oe));
endmodule : sfc_chk
bind sfc_serial_frame_control sfc_chk chk_u (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_rxd(i_rxd), .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_irq(o_irq));
`default_nettype wire

// ### sim/sfc_line_model.sv
// partner: remote transceiver that drives the receive line and captures frames
`timescale 1ns/1ps
`default_nettype none
module sfc_line_model (
  input  wire logic i_clk,
  input  wire logic i_txd,
  output logic      o_rxd
);
  initial o_rxd = 1'b1;
  // ----------------------------------------------------------------
  // line tasks
  // ----------------------------------------------------------------
  // start, data, stop lsb first; line rests high between frames
  task automatic send(input logic [10:0] f, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_rxd <= f[i];
      repeat (bt - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_rxd <= 1'b1;
  endtask : send
  // samples at falling edges, away from the launching edge
  task automatic recv(output logic [10:0] f, input int n, input int bt, output bit ok);
    f = 11'h7ff;
    for (int w = 0; w < 400; w++) begin
      @(negedge i_clk);
      if (i_txd === 1'b0) break;
    end
    ok = (i_txd === 1'b0);
    for (int i = 0; i < n && ok; i++) begin
      f[i] = i_txd;
      repeat (bt) @(negedge i_clk);
    end
  endtask : recv
endmodule : sfc_line_model
`default_nettype wire

// ### sim/test_serial_frame_control_reg.sv
// testbench: register and line tests of the serial frame control block
`timescale 1ns/1ps
`default_nettype none
module test_serial_frame_control_reg;
  import sfc_pkg::*;
  logic        i_clk   = 1'b0;
  logic        i_rst   = 1'b1;
  logic [2:0]  i_addr  = 3'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  logic [7:0]  o_rdata, v;
  logic        rxd, o_txd, o_txd_oe, o_irq;
  logic [10:0] f, e;
  bit          ok;
  int          mismatches = 0;
  int          num_checks = 0;
  // 8/9 bits, parity off/even/odd, interrupt enable, ninth bit, wake
  logic [7:0]  modes [6] = '{8'h00, 8'h05, 8'h07, 8'h50, 8'h16, 8'h48};
  always #5 i_clk = ~i_clk;
  sfc_serial_frame_control dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rxd),
    .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_irq(o_irq));
  sfc_line_model line_u (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask : rd
  // reads control in the very first cycle after release
  task automatic rst_rd();
    repeat (12) @(posedge i_clk);
    i_rst  <= 1'b0;
    i_rd   <= 1'b1;
    i_addr <= OFS_CTL1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, 8'h00);
  endtask : rst_rd
  // a lost frame counts as a mismatch and ends the run
  task automatic txf(input int n, input logic [10:0] x);
    line_u.recv(f, n, 2, ok);
    chk(ok, 1'b1);
    if (!ok) summarize();
    chk(f, x);
  endtask : txf
  // expected line frame: parity, when on, takes the top data slot
  function automatic logic [10:0] frm(input logic [7:0] d, input logic [7:0] c);
    logic nb;
    nb = c[CF_PCE] ? (^(c[CF_W9] ? d : {1'b0, d[6:0]})) ^ c[CF_PODD] : c[CF_TX9];
    if (c[CF_W9]) return {1'b1, nb, d, 1'b0};
    return {2'b11, c[CF_PCE] ? nb : d[7], d[6:0], 1'b0};
  endfunction : frm
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_rd();
    rd(3'h7, v);
    chk(v, 8'h00);
    wr(OFS_CTL1, 8'hff);
    rd(OFS_CTL1, v);
    chk(v, 8'h7f);
    wr(OFS_BAUD, 8'h01);
    wr(OFS_CTL2, 8'h03);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CTL1, modes[i]);
      wr(OFS_DATA, 8'(8'hc3 + i * 29));
      // parity settings flipped mid-frame must not touch this frame
      wr(OFS_CTL1, modes[i] ^ 8'h06);
      txf(modes[i][CF_W9] ? 11 : 10, frm(8'(8'hc3 + i * 29), modes[i]));
      wr(OFS_CTL1, modes[i]);
      for (int b = 0; b < 2; b++) begin
        e = frm(8'(8'h3c + i * 71), modes[i]);
        e[modes[i][CF_W9] ? 9 : 8] ^= b[0];
        line_u.send(e, modes[i][CF_W9] ? 11 : 10, 2);
        repeat (4) @(posedge i_clk);
        rd(OFS_STAT, v);
        chk({v[ST_RDRF], v[ST_PE]}, {1'b1, b[0] & modes[i][CF_PCE]});
        chk(o_irq, b[0] & modes[i][CF_PCE] & modes[i][CF_PIE]);
        rd(OFS_DATA, v);
        chk(v, e[8:1]);
        chk(o_irq, 1'b0);
        rd(OFS_CTL1, v);
        if (modes[i][CF_W9]) chk(v[CF_RX9], e[9]);
      end
    end
    // receive-word interrupt: masked in, then cleared by reading
    rd(OFS_IST, v);
    wr(OFS_IMSK, 8'h02);
    line_u.send(11'h702, 10, 2);
    repeat (4) @(posedge i_clk);
    chk(o_irq, 1'b1);
    rd(OFS_IST, v);
    chk(v[IR_RX], 1'b1);
    chk(o_irq, 1'b0);
    // mute: plain word dropped, address word wakes
    wr(OFS_CTL2, 8'h07);
    line_u.send(11'h602, 10, 2);
    repeat (4) @(posedge i_clk);
    chk(o_irq, 1'b0);
    line_u.send(11'h702, 10, 2);
    repeat (4) @(posedge i_clk);
    chk(o_irq, 1'b1);
    // low-power stop lands mid-frame: frame completes, then all halts
    wr(OFS_CTL1, 8'h00);
    wr(OFS_DATA, 8'h5a);
    wr(OFS_CTL1, 8'h20);
    txf(10, frm(8'h5a, 8'h00));
    repeat (4) @(posedge i_clk);
    chk(o_txd_oe, 1'b0);
    wr(OFS_DATA, 8'h00);
    line_u.recv(f, 10, 2, ok);
    chk(ok, 1'b0);
    @(posedge i_clk);
    i_rst <= 1'b1;
    rst_rd();
    summarize();
  end
endmodule : test_serial_frame_control_reg
`default_nettype wire
